/* File: gpio_board.sv */
// board model: each pin shows the device drive or an outside part
// assumes outside parts let go of a pin while the device drives it
`timescale 1ns/1ps
module gpio_board #(
    parameter int N = 40
) (
    // drive from the device
    input  wire logic [N-1:0] pad_out,
    input  wire logic [N-1:0] pad_oe,
    // outside level and resolved pin
    input  wire logic [N-1:0] ext,
    output logic      [N-1:0] pad_in
);
    // undriven pins follow ext, which the bench keeps changing
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule : gpio_board

/* File: gpio_port_pkg.sv */
// constants shared by the configurable i/o port block
// assumes byte-wide ports on an i/o space reached by IN and OUT accesses
package gpio_port_pkg;

    // geometry
    localparam int PORT_COUNT  = 5;
    localparam int PORT_WIDTH  = 8;
    localparam int ADDR_WIDTH  = 8;
    localparam int ACC_WIDTH   = 16;
    localparam int SYNC_STAGES = 3;

    // register offsets in i/o space, four bytes apart
    localparam logic [ADDR_WIDTH-1:0] PORT_A_VALUE_OFFSET     = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] PORT_A_DIRECTION_OFFSET = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] PORT_B_VALUE_OFFSET     = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] PORT_B_DIRECTION_OFFSET = 8'h0C;
    localparam logic [ADDR_WIDTH-1:0] PORT_C_VALUE_OFFSET     = 8'h10;
    localparam logic [ADDR_WIDTH-1:0] PORT_C_DIRECTION_OFFSET = 8'h14;
    localparam logic [ADDR_WIDTH-1:0] PORT_D_VALUE_OFFSET     = 8'h18;
    localparam logic [ADDR_WIDTH-1:0] PORT_D_DIRECTION_OFFSET = 8'h1C;
    localparam logic [ADDR_WIDTH-1:0] PORT_E_VALUE_OFFSET     = 8'h20;
    localparam logic [ADDR_WIDTH-1:0] PORT_E_DIRECTION_OFFSET = 8'h24;

    // offset tables, entry 0 is port a
    localparam logic [PORT_COUNT-1:0][ADDR_WIDTH-1:0] VALUE_OFFSETS = {
        PORT_E_VALUE_OFFSET, PORT_D_VALUE_OFFSET, PORT_C_VALUE_OFFSET,
        PORT_B_VALUE_OFFSET, PORT_A_VALUE_OFFSET};
    localparam logic [PORT_COUNT-1:0][ADDR_WIDTH-1:0] DIRECTION_OFFSETS = {
        PORT_E_DIRECTION_OFFSET, PORT_D_DIRECTION_OFFSET,
        PORT_C_DIRECTION_OFFSET, PORT_B_DIRECTION_OFFSET,
        PORT_A_DIRECTION_OFFSET};

    // reset values
    localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 8'h00;
    localparam logic [ACC_WIDTH-1:0]  READ_RESET      = 16'h0000;

endpackage : gpio_port_pkg

/* File: gpio_ports.sv */
// five byte-wide configurable i/o ports on the core's i/o space
// assumes io_rd and io_wr are one-cycle strobes from the core on clock,
// and that the pad ring resolves pad_out/pad_oe into the pin level
`timescale 1ns/1ps

module gpio_ports
    import gpio_port_pkg::*;
#(
    parameter int PORTS = PORT_COUNT
) (
    // clock and reset
    input  wire logic                              clock,
    input  wire logic                              nrst,
    // core i/o space access
    input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0] io_addr,
    input  wire logic                              io_rd,
    input  wire logic                              io_wr,
    input  wire logic [gpio_port_pkg::ACC_WIDTH-1:0]  io_wdata,
    output logic      [gpio_port_pkg::ACC_WIDTH-1:0]  io_rdata,
    // pins, port a in bits 7:0 up to port e in bits 39:32
    input  wire logic [PORTS*gpio_port_pkg::PORT_WIDTH-1:0] pad_in,
    output logic      [PORTS*gpio_port_pkg::PORT_WIDTH-1:0] pad_out,
    output logic      [PORTS*gpio_port_pkg::PORT_WIDTH-1:0] pad_oe
);
    import gpio_port_pkg::*;

    localparam int PIN_COUNT = PORTS * PORT_WIDTH;

    ////////////////////////////////////////////////////////////////////////
    // elaboration check

    // the offset tables only describe the documented five ports
    generate
        if (PORTS < 1 || PORTS > PORT_COUNT) begin : g_bad_ports
            $error("gpio_ports: PORTS must lie between 1 and PORT_COUNT");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [PIN_COUNT-1:0] pin_level;

    // pins are asynchronous to the core, so filter before reading
    pin_synchronizer #(
        .WIDTH (PIN_COUNT)
    ) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .raw   (pad_in),
        .level (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // address decode

    logic [PORTS-1:0]      hit_value;
    logic [PORTS-1:0]      hit_direction;
    logic [PORTS-1:0]      write_value;
    logic [PORTS-1:0]      write_direction;
    logic [PORT_WIDTH-1:0] write_data;

    // only the low byte of the accumulator reaches a port
    assign write_data = io_wdata[PORT_WIDTH-1:0];

    // full compare: the unused bytes of each 4-byte slot are unmapped
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            hit_value[p]       = (io_addr == VALUE_OFFSETS[p]);
            hit_direction[p]   = (io_addr == DIRECTION_OFFSETS[p]);
            write_value[p]     = io_wr && hit_value[p];
            write_direction[p] = io_wr && hit_direction[p];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ports

    logic [PORTS-1:0][PORT_WIDTH-1:0] direction;

    // one slice per port, each pin independently steered
    generate
        for (genvar p = 0; p < PORTS; p++) begin : g_port
            port_slice u_port (
                .clock           (clock),
                .nrst            (nrst),
                .write_value     (write_value[p]),
                .write_direction (write_direction[p]),
                .write_data      (write_data),
                .direction       (direction[p]),
                .pad_out         (pad_out[p*PORT_WIDTH +: PORT_WIDTH]),
                .pad_oe          (pad_oe[p*PORT_WIDTH +: PORT_WIDTH])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read path

    logic [PORT_WIDTH-1:0] read_byte;
    logic [ACC_WIDTH-1:0]  next_rdata;

    // value reads show the pin itself, not the stored value, so an
    // output pin that is overloaded reads back its true level
    always_comb begin
        read_byte = '0;
        for (int p = 0; p < PORTS; p++) begin
            if (hit_value[p]) begin
                read_byte = pin_level[p*PORT_WIDTH +: PORT_WIDTH];
            end
            if (hit_direction[p]) begin
                read_byte = direction[p];
            end
        end
    end

    // result held until the next IN; upper byte always zero
    always_comb begin
        next_rdata = io_rdata;
        if (io_rd) begin
            next_rdata = {{(ACC_WIDTH-PORT_WIDTH){1'b0}}, read_byte};
        end
    end

    // registered read data
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= READ_RESET;
        end else begin
            io_rdata <= next_rdata;
        end
    end

endmodule : gpio_ports

/* File: gpio_ports_chk.sv */
// checker for the configurable i/o ports, sees only top ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
module gpio_ports_chk #(
    parameter int PORTS = 5
) (
    // clock and reset
    input wire logic                 clock,
    input wire logic                 nrst,
    // i/o space access
    input wire logic [7:0]           io_addr,
    input wire logic                 io_rd,
    input wire logic                 io_wr,
    input wire logic [15:0]          io_wdata,
    input wire logic [15:0]          io_rdata,
    // pins
    input wire logic [PORTS*8-1:0]   pad_in,
    input wire logic [PORTS*8-1:0]   pad_out,
    input wire logic [PORTS*8-1:0]   pad_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////
    // read path
    AST_UPPER_ZERO: assert property (io_rdata[15:8] == 8'h00)
        else $error("read upper byte not zero");
    AST_RD_HOLD: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property (io_rd && io_addr[1:0] != 2'b00
        |=> io_rdata == 16'h0000) else $error("unmapped read not zero");
    AST_DIR_READ: assert property (io_rd && !io_wr && io_addr == 8'h04
        |=> io_rdata[7:0] == $past(pad_oe[7:0]))
        else $error("direction read differs from enables");

    ////////////////////////////////////////////////////////////////////
    // write path and drivers
    AST_INPUT_QUIET: assert property ((pad_out & ~pad_oe) == '0)
        else $error("input pin drives a level");
    AST_DIR_WRITE: assert property (io_wr && io_addr == 8'h04
        |=> pad_oe[7:0] == $past(io_wdata[7:0]))
        else $error("direction write not applied");
    AST_VAL_WRITE: assert property (io_wr && io_addr == 8'h00
        |=> pad_out[7:0] == ($past(io_wdata[7:0]) & pad_oe[7:0]))
        else $error("value write not driven");
    AST_OE_HOLD: assert property (!io_wr |=> $stable(pad_oe))
        else $error("enables moved without a write");
    // reset is the one case watched while reset is low; the first edge
    // in reset is skipped, since the async clear may not have landed yet
    AST_RESET_DIR: assert property (@(posedge clock) disable iff (1'b0)
        !nrst && !$past(nrst) |-> pad_oe == '0)
        else $error("enables set in reset");

    ////////////////////////////////////////////////////////////////////
    // main scenarios
    cover property (io_wr && io_addr == 8'h04);
    cover property (io_rd && io_addr == 8'h00);
    cover property (io_rd && io_addr == 8'h01);
endmodule : gpio_ports_chk

bind gpio_ports gpio_ports_chk #(.PORTS(PORTS)) u_gpio_ports_chk (
    .clock, .nrst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
    .pad_in, .pad_out, .pad_oe);

/* File: pin_synchronizer.sv */
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to clock; one bit per pin
`timescale 1ns/1ps
module pin_synchronizer #(
    parameter int WIDTH = 40
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // raw pins and clean levels
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // level moves only when the last two stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage2[i] : level[i];
        end
    end

    // stage1 feeds stage2 only, to keep metastability contained
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

endmodule : pin_synchronizer

/* File: port_slice.sv */
// one byte-wide port: direction and value registers and pin drivers
// assumes write strobes already decoded and one cycle wide
`timescale 1ns/1ps
module port_slice
    import gpio_port_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  nrst,
    // decoded writes
    input  wire logic                  write_value,
    input  wire logic                  write_direction,
    input  wire logic [PORT_WIDTH-1:0] write_data,
    // register state
    output logic      [PORT_WIDTH-1:0] direction,
    // pin drive
    output logic      [PORT_WIDTH-1:0] pad_out,
    output logic      [PORT_WIDTH-1:0] pad_oe
);

    logic [PORT_WIDTH-1:0] value;
    logic [PORT_WIDTH-1:0] next_value;
    logic [PORT_WIDTH-1:0] next_direction;

    // next register values on an OUT access
    always_comb begin
        next_value     = write_value ? write_data : value;
        next_direction = write_direction ? write_data : direction;
    end

    // value has no reset: software must load it before enabling outputs
    always_ff @(posedge clock) begin
        value <= next_value;
    end

    // direction clears on reset, so all pins come up as inputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            direction <= DIRECTION_RESET;
        end else begin
            direction <= next_direction;
        end
    end

    // gating by direction also hides the unknown value after reset
    always_comb begin
        pad_oe  = direction;
        pad_out = value & direction;
    end

endmodule : port_slice

/* File: tb_gpio_ports.sv */
// self-checking bench for the five configurable i/o ports
// assumes gpio_board resolves pins; inputs change on falling edges
`timescale 1ns/1ps
module tb_gpio_ports;
    import gpio_port_pkg::*;
    logic        clock, nrst, io_rd, io_wr;
    logic [7:0]  io_addr, dir, val, pin;
    logic [15:0] io_wdata, io_rdata, rv;
    logic [39:0] pad_in, pad_out, pad_oe, ext, oe0;
    int          err_count, num_checks, p, i;
    logic [7:0]  bad [4] = '{8'h01, 8'h05, 8'h28, 8'h3F};

    gpio_ports u_gpio_ports (.clock, .nrst, .io_addr, .io_rd, .io_wr,
        .io_wdata, .io_rdata, .pad_in, .pad_out, .pad_oe);
    gpio_board u_gpio_board (.pad_out, .pad_oe, .ext, .pad_in);

    ////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        #20000;
        err_count++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input logic [39:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    // strobe held over one rising edge; data is settled by next fall
    task automatic acc(input logic rd, input logic [7:0] a,
                       input logic [15:0] d);
        @(negedge clock);
        io_rd = rd;
        io_wr = ~rd;
        io_addr = a;
        io_wdata = d;
        @(negedge clock);
        io_rd = 1'b0;
        io_wr = 1'b0;
        rv = io_rdata;
    endtask : acc
    function automatic logic [7:0] exp_pin(input logic [7:0] d, v, e);
        return (d & v) | (~d & e);
    endfunction : exp_pin
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {nrst, io_rd, io_wr, io_addr, io_wdata, ext} = '0;
        void'($urandom(53));
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        chk(pad_oe, '0, "oe after reset");
        for (p = 0; p < PORT_COUNT; p++) begin
            acc(1'b1, DIRECTION_OFFSETS[p], 16'h0000);
            chk(rv, 16'h0000, "direction reset");
        end
        // first ten passes all-input then all-output, then random mixes
        for (i = 0; i < 40; i++) begin
            p = i % PORT_COUNT;
            dir = (i < 5) ? 8'h00 : (i < 10) ? 8'hFF : 8'($urandom);
            val = 8'($urandom);
            ext = {8'($urandom), $urandom};
            acc(1'b0, DIRECTION_OFFSETS[p], {8'($urandom), dir});
            acc(1'b0, VALUE_OFFSETS[p], {8'($urandom), val});
            repeat (5) @(negedge clock);
            pin = exp_pin(dir, val, ext[p*8 +: 8]);
            chk(pad_oe[p*8 +: 8], dir, "enables");
            chk(pad_out[p*8 +: 8], val & dir, "drive");
            acc(1'b1, VALUE_OFFSETS[p], 16'h0000);
            chk(rv, {8'h00, pin}, "value read");
            acc(1'b1, DIRECTION_OFFSETS[p], 16'h0000);
            chk(rv, {8'h00, dir}, "direction read");
        end
        // off-map places ignore writes and read as zero
        foreach (bad[k]) begin
            oe0 = pad_oe;
            acc(1'b0, bad[k], 16'hFFFF);
            chk(pad_oe, oe0, "off-map write");
            acc(1'b1, bad[k], 16'h0000);
            chk(rv, 16'h0000, "off-map read");
        end
        // second reset in mid-run frees every pin
        @(negedge clock);
        nrst = 1'b0;
        repeat (2) @(negedge clock);
        chk(pad_oe, '0, "oe in reset");
        chk(pad_out, '0, "drive in reset");
        nrst = 1'b1;
        acc(1'b1, DIRECTION_OFFSETS[4], 16'h0000);
        chk(rv, 16'h0000, "direction after reset");
        conclude();
    end
endmodule : tb_gpio_ports
